//--- hdl/dcs_defs.svh
// Constants of the disk command block and sense logic
// Assumes a 250 MHz system clock; times are given in ns
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

`define DCS_CLK_NS         4
`define DCS_STEP_3MS_NS    3000000
`define DCS_STEP_200US_NS  200000
`define DCS_STEP_70US_NS   70000
`define DCS_STEP_3MS_CYC   (`DCS_STEP_3MS_NS / `DCS_CLK_NS)
`define DCS_STEP_200US_CYC (`DCS_STEP_200US_NS / `DCS_CLK_NS)
`define DCS_STEP_70US_CYC  (`DCS_STEP_70US_NS / `DCS_CLK_NS)
`define DCS_STEP_CNT_W     20

`define DCS_BLOCK_LEN      3'h6
`define DCS_LAST_BYTE      3'h5
`define DCS_SENSE_LAST     2'h3
`define DCS_RETRY_COUNT    3'h4

`define DCS_CTL_RETRY_OFF  7
`define DCS_CTL_NO_REREAD  6
`define DCS_STEP_200US_SEL 3'h4
`define DCS_STEP_70US_SEL  3'h5

`define DCS_CODE_NONE      6'h00
`define DCS_CODE_NO_INDEX  6'h01
`define DCS_CODE_NO_SEEK   6'h02
`define DCS_CODE_WR_FAULT  6'h03
`define DCS_CODE_NOT_READY 6'h04
`define DCS_CODE_NO_TRK0   6'h06
`define DCS_CODE_SEEKING   6'h08
`define DCS_CODE_ID_ECC    6'h10
`define DCS_CODE_DATA_ECC  6'h11
`define DCS_CODE_NO_MARK   6'h12
`define DCS_CODE_NO_SECTOR 6'h14
`define DCS_CODE_SEEK_ERR  6'h15
`define DCS_CODE_CORR_ECC  6'h18
`define DCS_CODE_BAD_TRACK 6'h19
`define DCS_CODE_BAD_CMD   6'h20
`define DCS_CODE_BAD_ADDR  6'h21
`define DCS_CODE_RAM_ERR   6'h30
`define DCS_CODE_ROM_SUM   6'h31
`define DCS_CODE_ECC_TEST  6'h32

`endif

//--- hdl/dcs_pkg.sv
// Types of the disk command block and sense logic
// Assumes dcs_defs.svh is compiled alongside
package dcs_pkg;

  // Failure causes reported by the sequencer at command end
  typedef enum logic [4:0] {
    DCS_CAUSE_NONE       = 5'h00,
    DCS_CAUSE_NO_INDEX   = 5'h01,
    DCS_CAUSE_NO_SEEK    = 5'h02,
    DCS_CAUSE_WR_FAULT   = 5'h03,
    DCS_CAUSE_NOT_READY  = 5'h04,
    DCS_CAUSE_NO_TRK0    = 5'h05,
    DCS_CAUSE_SEEKING    = 5'h06,
    DCS_CAUSE_ID_ECC     = 5'h07,
    DCS_CAUSE_DATA_ECC   = 5'h08,
    DCS_CAUSE_NO_MARK    = 5'h09,
    DCS_CAUSE_NO_SECTOR  = 5'h0a,
    DCS_CAUSE_SEEK_ERR   = 5'h0b,
    DCS_CAUSE_CORR_ECC   = 5'h0c,
    DCS_CAUSE_BAD_TRACK  = 5'h0d,
    DCS_CAUSE_BAD_CMD    = 5'h0e,
    DCS_CAUSE_BAD_ADDR   = 5'h0f,
    DCS_CAUSE_RAM_ERR    = 5'h10,
    DCS_CAUSE_ROM_SUM    = 5'h11,
    DCS_CAUSE_ECC_TEST   = 5'h12
  } dcs_cause_t;

  typedef enum logic [1:0] {
    DCS_ST_IDLE  = 2'b00,
    DCS_ST_LOAD  = 2'b01,
    DCS_ST_BUSY  = 2'b10,
    DCS_ST_SENSE = 2'b11
  } dcs_state_t;

  typedef struct packed {
    dcs_state_t       state;
    logic [2:0]       byte_idx;
    logic [5:0][7:0]  block;
    logic             block_ready;
    logic [5:0]       sense_code;
    logic             addr_valid;
    logic             status_err;
    logic             bad_track;
    logic [1:0]       sense_idx;
    logic [7:0]       sense_byte;
    logic             sense_valid;
    logic [19:0]      step_cnt;
    logic             step_pulse;
    logic             busy;
    logic             reread_ok;
    logic [2:0]       retry_limit;
  } dcs_state_s_t;

endpackage

//--- hdl/dcs_command_sense.sv
// Command block capture, field decode, step timing and sense reporting
// Assumes byte strobes and sequencer events come from logic on sys_clk_in
`timescale 1ns/100ps
`include "dcs_defs.svh"

module dcs_command_sense #(
  parameter logic [19:0] STEP_3MS_CYC   = 20'(`DCS_STEP_3MS_CYC),
  parameter logic [19:0] STEP_200US_CYC = 20'(`DCS_STEP_200US_CYC),
  parameter logic [19:0] STEP_70US_CYC  = 20'(`DCS_STEP_70US_CYC)
) (
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_n_in,
  // Command block bytes from the data register
  input  wire logic                 cmd_wr_in,
  input  wire logic [7:0]           cmd_byte_in,
  // Sequencer events
  input  wire logic                 cmd_done_in,
  input  wire dcs_pkg::dcs_cause_t  cmd_cause_in,
  input  wire logic                 cmd_addr_used_in,
  input  wire logic                 step_run_in,
  // Sense byte fetch
  input  wire logic                 sense_rd_in,
  // Decoded command block
  output logic                      block_ready_out,
  output logic [2:0]                cmd_class_out,
  output logic [4:0]                cmd_opcode_out,
  output logic                      drive_sel_out,
  output logic [4:0]                head_out,
  output logic [9:0]                cylinder_out,
  output logic [5:0]                sector_out,
  output logic [7:0]                count_out,
  output logic                      retry_off_out,
  output logic                      reread_ok_out,
  output logic [2:0]                retry_limit_out,
  // Step timing
  output logic                      step_pulse_out,
  // Completion status and sense
  output logic                      status_err_out,
  output logic                      busy_out,
  output logic [7:0]                sense_byte_out,
  output logic                      sense_valid_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Only listed codes can come out; unused codes have no cause
  function automatic logic [5:0] cause_code(input dcs_pkg::dcs_cause_t c);
    logic [5:0] code;
    code = `DCS_CODE_NONE;
    unique case (c)
      dcs_pkg::DCS_CAUSE_NONE:      code = `DCS_CODE_NONE;
      dcs_pkg::DCS_CAUSE_NO_INDEX:  code = `DCS_CODE_NO_INDEX;
      dcs_pkg::DCS_CAUSE_NO_SEEK:   code = `DCS_CODE_NO_SEEK;
      dcs_pkg::DCS_CAUSE_WR_FAULT:  code = `DCS_CODE_WR_FAULT;
      dcs_pkg::DCS_CAUSE_NOT_READY: code = `DCS_CODE_NOT_READY;
      dcs_pkg::DCS_CAUSE_NO_TRK0:   code = `DCS_CODE_NO_TRK0;
      dcs_pkg::DCS_CAUSE_SEEKING:   code = `DCS_CODE_SEEKING;
      dcs_pkg::DCS_CAUSE_ID_ECC:    code = `DCS_CODE_ID_ECC;
      dcs_pkg::DCS_CAUSE_DATA_ECC:  code = `DCS_CODE_DATA_ECC;
      dcs_pkg::DCS_CAUSE_NO_MARK:   code = `DCS_CODE_NO_MARK;
      dcs_pkg::DCS_CAUSE_NO_SECTOR: code = `DCS_CODE_NO_SECTOR;
      dcs_pkg::DCS_CAUSE_SEEK_ERR:  code = `DCS_CODE_SEEK_ERR;
      dcs_pkg::DCS_CAUSE_CORR_ECC:  code = `DCS_CODE_CORR_ECC;
      dcs_pkg::DCS_CAUSE_BAD_TRACK: code = `DCS_CODE_BAD_TRACK;
      dcs_pkg::DCS_CAUSE_BAD_CMD:   code = `DCS_CODE_BAD_CMD;
      dcs_pkg::DCS_CAUSE_BAD_ADDR:  code = `DCS_CODE_BAD_ADDR;
      dcs_pkg::DCS_CAUSE_RAM_ERR:   code = `DCS_CODE_RAM_ERR;
      dcs_pkg::DCS_CAUSE_ROM_SUM:   code = `DCS_CODE_ROM_SUM;
      dcs_pkg::DCS_CAUSE_ECC_TEST:  code = `DCS_CODE_ECC_TEST;
      default:                      code = `DCS_CODE_NONE;
    endcase
    return code;
  endfunction

  function automatic logic [19:0] step_interval(input logic [2:0] sel);
    logic [19:0] n;
    n = STEP_3MS_CYC;
    if (sel == `DCS_STEP_200US_SEL) begin
      n = STEP_200US_CYC;
    end else if (sel == `DCS_STEP_70US_SEL) begin
      n = STEP_70US_CYC;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  dcs_pkg::dcs_state_s_t st_reg;
  dcs_pkg::dcs_state_s_t st_next;

  // Idle with the full retry budget and rereads allowed, as a cleared control byte implies
  localparam dcs_pkg::dcs_state_s_t ST_RESET = '{state:       dcs_pkg::DCS_ST_IDLE,
                                                 reread_ok:   1'b1,
                                                 retry_limit: `DCS_RETRY_COUNT,
                                                 default:     '0};

  always_comb begin
    st_next             = st_reg;
    st_next.block_ready = 1'b0;
    st_next.step_pulse  = 1'b0;
    st_next.sense_valid = 1'b0;

    unique case (st_reg.state)
      dcs_pkg::DCS_ST_IDLE, dcs_pkg::DCS_ST_SENSE: begin
        // A new block abandons any unread sense bytes
        if (cmd_wr_in) begin
          st_next.block[0]   = cmd_byte_in;
          st_next.byte_idx   = 3'h1;
          st_next.status_err = 1'b0;
          st_next.state      = dcs_pkg::DCS_ST_LOAD;
        end else if (st_reg.state == dcs_pkg::DCS_ST_SENSE && sense_rd_in) begin
          st_next.sense_valid = 1'b1;
          unique case (st_reg.sense_idx)
            2'h0: st_next.sense_byte = {st_reg.addr_valid, 1'b0, st_reg.sense_code};
            2'h1: st_next.sense_byte = {2'b00, st_reg.block[1][5:0]};
            2'h2: st_next.sense_byte = st_reg.block[2];
            2'h3: st_next.sense_byte = st_reg.block[3];
          endcase
          st_next.sense_idx = st_reg.sense_idx + 2'h1;
          if (st_reg.sense_idx == `DCS_SENSE_LAST) begin
            st_next.state = dcs_pkg::DCS_ST_IDLE;
          end
        end
      end
      dcs_pkg::DCS_ST_LOAD: begin
        if (cmd_wr_in) begin
          st_next.block[st_reg.byte_idx] = cmd_byte_in;
          st_next.byte_idx = st_reg.byte_idx + 3'h1;
          if (st_reg.byte_idx == `DCS_LAST_BYTE) begin
            st_next.block_ready = 1'b1;
            st_next.bad_track   = 1'b0;
            st_next.step_cnt    = step_interval(cmd_byte_in[2:0]);
            st_next.state       = dcs_pkg::DCS_ST_BUSY;
          end
        end
      end
      dcs_pkg::DCS_ST_BUSY: begin
        // Step cadence counted on the system clock
        if (step_run_in) begin
          if (st_reg.step_cnt <= 20'h00001) begin
            st_next.step_pulse = 1'b1;
            st_next.step_cnt   = step_interval(st_reg.block[5][2:0]);
          end else begin
            st_next.step_cnt = st_reg.step_cnt - 20'h00001;
          end
        end
        if (cmd_done_in) begin
          st_next.sense_code = cause_code(cmd_cause_in);
          st_next.addr_valid = cmd_addr_used_in;
          st_next.bad_track  = (cmd_cause_in == dcs_pkg::DCS_CAUSE_BAD_TRACK);
          st_next.sense_idx  = 2'h0;
          if (cmd_cause_in == dcs_pkg::DCS_CAUSE_NONE) begin
            st_next.status_err = 1'b0;
            st_next.state      = dcs_pkg::DCS_ST_IDLE;
          end else begin
            st_next.status_err = 1'b1;
            st_next.state      = dcs_pkg::DCS_ST_SENSE;
          end
        end
      end
    endcase

    // Derived flags are worked out from the next state so the registered copies keep their timing
    st_next.busy        = st_next.state != dcs_pkg::DCS_ST_IDLE;
    st_next.reread_ok   = ~st_next.block[5][`DCS_CTL_NO_REREAD];
    // Bad track suppresses retries once flagged, whatever the control byte says
    st_next.retry_limit = (st_next.block[5][`DCS_CTL_RETRY_OFF] || st_next.bad_track) ?
                          3'h0 : `DCS_RETRY_COUNT;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= ST_RESET;
    end else if (!rst_sync_reg) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken from state flip-flops
  // ----------------------------------------------------------------
  assign block_ready_out = st_reg.block_ready;
  assign cmd_class_out   = st_reg.block[0][7:5];
  assign cmd_opcode_out  = st_reg.block[0][4:0];
  assign drive_sel_out   = st_reg.block[1][5];
  assign head_out        = st_reg.block[1][4:0];
  assign cylinder_out    = {st_reg.block[2][7:6], st_reg.block[3]};
  assign sector_out      = st_reg.block[2][5:0];
  assign count_out       = st_reg.block[4];
  assign retry_off_out   = st_reg.block[5][`DCS_CTL_RETRY_OFF];
  assign reread_ok_out   = st_reg.reread_ok;
  assign retry_limit_out = st_reg.retry_limit;
  assign step_pulse_out  = st_reg.step_pulse;
  assign status_err_out  = st_reg.status_err;
  assign busy_out        = st_reg.busy;
  assign sense_byte_out  = st_reg.sense_byte;
  assign sense_valid_out = st_reg.sense_valid;

endmodule

//--- tb/dcs_seq_model.sv
// Behavioural sequencer that finishes each captured command block
// Assumes one clock shared with the block; the bench sets cause and delay
`timescale 1ns/100ps

module dcs_seq_model (
  // Clock and trigger
  input  wire logic                sys_clk_in,
  input  wire logic                block_ready_in,
  // Settings for the next completion
  input  wire dcs_pkg::dcs_cause_t cause_in,
  input  wire logic                addr_in,
  input  wire logic                step_en_in,
  input  wire logic [7:0]          wait_in,
  // Sequencer events
  output logic                     cmd_done_out,
  output dcs_pkg::dcs_cause_t      cmd_cause_out,
  output logic                     cmd_addr_used_out,
  output logic                     step_run_out
);
  logic [7:0] cnt_reg = 8'h00;
  initial begin
    cmd_done_out = 1'b0;
    cmd_cause_out = dcs_pkg::DCS_CAUSE_NONE;
    cmd_addr_used_out = 1'b0;
  end
  // Cause and flag toggle outside the pulse so a stale value never looks valid
  always @(posedge sys_clk_in) begin
    cmd_done_out <= 1'b0;
    cmd_cause_out <= dcs_pkg::dcs_cause_t'(~cmd_cause_out);
    cmd_addr_used_out <= ~cmd_addr_used_out;
    if (block_ready_in) cnt_reg <= wait_in;
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
    if (cnt_reg == 8'h01) begin
      cmd_done_out <= 1'b1;
      cmd_cause_out <= cause_in;
      cmd_addr_used_out <= addr_in;
    end
  end
  assign step_run_out = step_en_in && (cnt_reg != 8'h00);
endmodule

//--- tb/dcs_command_sense_properties.sv
// Port timing checks for the command block and sense logic
// Assumes it is bound into dcs_command_sense, one clock domain
`timescale 1ns/100ps

module dcs_command_sense_properties (
  input wire logic                sys_clk_in, reset_n_in, cmd_wr_in, cmd_done_in, cmd_addr_used_in, sense_rd_in,
  input wire dcs_pkg::dcs_cause_t cmd_cause_in,
  input wire logic                block_ready_out, drive_sel_out, retry_off_out, step_pulse_out, status_err_out,
  input wire logic                busy_out, sense_valid_out,
  input wire logic [4:0]          head_out,
  input wire logic [9:0]          cylinder_out,
  input wire logic [5:0]          sector_out,
  input wire logic [2:0]          retry_limit_out,
  input wire logic [7:0]          sense_byte_out
);
  logic       run_reg;
  logic       addr_reg;
  logic [1:0] idx_reg;
  // Tracks which sense byte is shown and what the last completion flagged
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_reg <= 1'b0;
      addr_reg <= 1'b0;
      idx_reg <= 2'h0;
    end else begin
      if (block_ready_out) run_reg <= 1'b1;
      else if (cmd_done_in) run_reg <= 1'b0;
      if (cmd_done_in && run_reg) addr_reg <= cmd_addr_used_in;
      if (block_ready_out) idx_reg <= 2'h0;
      else if (sense_valid_out) idx_reg <= idx_reg + 2'h1;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_spare_bit: assert property (sense_valid_out && idx_reg == 2'h0 |-> !sense_byte_out[6])
    else $error("sense spare bit set");
  chk_addr_valid: assert property (sense_valid_out && idx_reg == 2'h0 |-> sense_byte_out[7] == addr_reg)
    else $error("address valid bit wrong");
  chk_sense_head: assert property (sense_valid_out && idx_reg == 2'h1 |->
    sense_byte_out == {2'b00, drive_sel_out, head_out}) else $error("sense byte 1 wrong");
  chk_sense_cyl: assert property (sense_valid_out && idx_reg == 2'h2 |->
    sense_byte_out == {cylinder_out[9:8], sector_out}) else $error("sense byte 2 wrong");
  chk_sense_low: assert property (sense_valid_out && idx_reg == 2'h3 |-> sense_byte_out == cylinder_out[7:0])
    else $error("sense byte 3 wrong");
  chk_err_status: assert property (cmd_done_in && run_reg |=>
    status_err_out == ($past(cmd_cause_in) != dcs_pkg::DCS_CAUSE_NONE)) else $error("error status wrong");
  chk_retry_off: assert property (block_ready_out |-> retry_limit_out == (retry_off_out ? 3'h0 : 3'h4))
    else $error("retry limit wrong");
  chk_bad_track: assert property (cmd_done_in && run_reg && cmd_cause_in == dcs_pkg::DCS_CAUSE_BAD_TRACK |=>
    retry_limit_out == 3'h0) else $error("bad track retried");
  chk_sense_ans: assert property (sense_rd_in && status_err_out && busy_out && !run_reg && !cmd_wr_in |=>
    sense_valid_out) else $error("sense fetch unanswered");
  chk_step_gap: assert property (step_pulse_out |=> !step_pulse_out [*8]) else $error("steps too close");
endmodule

bind dcs_command_sense dcs_command_sense_properties i_chk (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .cmd_wr_in(cmd_wr_in), .cmd_done_in(cmd_done_in), .cmd_addr_used_in(cmd_addr_used_in),
  .sense_rd_in(sense_rd_in), .cmd_cause_in(cmd_cause_in), .block_ready_out(block_ready_out),
  .drive_sel_out(drive_sel_out), .retry_off_out(retry_off_out), .step_pulse_out(step_pulse_out),
  .status_err_out(status_err_out), .busy_out(busy_out), .sense_valid_out(sense_valid_out), .head_out(head_out),
  .cylinder_out(cylinder_out), .sector_out(sector_out), .retry_limit_out(retry_limit_out),
  .sense_byte_out(sense_byte_out));

//--- tb/tb.sv
// Self-checking bench for the command block and sense logic
// Assumes dcs_seq_model finishes each block; step counts shortened to 30, 20, 10
`timescale 1ns/100ps

module tb;
  logic sys_clk_in = 1'b0, reset_n_in = 1'b0, cmd_wr_in = 1'b0, sense_rd_in = 1'b0;
  logic [7:0] cmd_byte_in = 8'h00;
  logic cmd_done_in, cmd_addr_used_in, step_run_in, block_ready_out, drive_sel_out, retry_off_out;
  logic reread_ok_out, step_pulse_out, status_err_out, busy_out, sense_valid_out;
  logic [2:0] cmd_class_out, retry_limit_out;
  logic [4:0] cmd_opcode_out, head_out;
  logic [9:0] cylinder_out;
  logic [5:0] sector_out;
  logic [7:0] count_out, sense_byte_out, m_wait = 8'h08;
  logic [7:0] b [6];
  dcs_pkg::dcs_cause_t cmd_cause_in, m_cause = dcs_pkg::DCS_CAUSE_NONE;
  logic m_addr = 1'b0, m_step = 1'b0;
  int err_total = 0, samples_checked = 0, cycles = 0, n;
  // Rows: failure cause beside the sense code it must produce
  logic [10:0] rows [19] = '{{5'h00, 6'h00}, {5'h01, 6'h01}, {5'h02, 6'h02}, {5'h03, 6'h03}, {5'h04, 6'h04},
    {5'h05, 6'h06}, {5'h06, 6'h08}, {5'h07, 6'h10}, {5'h08, 6'h11}, {5'h09, 6'h12}, {5'h0a, 6'h14},
    {5'h0b, 6'h15}, {5'h0c, 6'h18}, {5'h0d, 6'h19}, {5'h0e, 6'h20}, {5'h0f, 6'h21}, {5'h10, 6'h30},
    {5'h11, 6'h31}, {5'h12, 6'h32}};
  always #2 sys_clk_in = ~sys_clk_in;
  dcs_command_sense #(.STEP_3MS_CYC(20'h0001e), .STEP_200US_CYC(20'h00014), .STEP_70US_CYC(20'h0000a)) i_dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cmd_wr_in(cmd_wr_in), .cmd_byte_in(cmd_byte_in),
    .cmd_done_in(cmd_done_in), .cmd_cause_in(cmd_cause_in), .cmd_addr_used_in(cmd_addr_used_in),
    .step_run_in(step_run_in), .sense_rd_in(sense_rd_in), .block_ready_out(block_ready_out),
    .cmd_class_out(cmd_class_out), .cmd_opcode_out(cmd_opcode_out), .drive_sel_out(drive_sel_out),
    .head_out(head_out), .cylinder_out(cylinder_out), .sector_out(sector_out), .count_out(count_out),
    .retry_off_out(retry_off_out), .reread_ok_out(reread_ok_out), .retry_limit_out(retry_limit_out),
    .step_pulse_out(step_pulse_out), .status_err_out(status_err_out), .busy_out(busy_out),
    .sense_byte_out(sense_byte_out), .sense_valid_out(sense_valid_out));
  dcs_seq_model i_seq (.sys_clk_in(sys_clk_in), .block_ready_in(block_ready_out), .cause_in(m_cause),
    .addr_in(m_addr), .step_en_in(m_step), .wait_in(m_wait), .cmd_done_out(cmd_done_in),
    .cmd_cause_out(cmd_cause_in), .cmd_addr_used_out(cmd_addr_used_in), .step_run_out(step_run_in));

  task automatic wrap_up;
    $display("Checked %0d values, %0d mismatches", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic send(input logic [7:0] d [6]);
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk_in);
      cmd_wr_in <= 1'b1;
      cmd_byte_in <= d[k];
    end
    @(posedge sys_clk_in);
    cmd_wr_in <= 1'b0;
    cmd_byte_in <= ~d[5];
    #1;
  endtask
  task automatic wait_done;
    for (int i = 0; i < 300 && cmd_done_in !== 1'b1; i++) tick;
    tick;
  endtask
  task automatic sense(input logic [7:0] e0, e1, e2, e3);
    logic [7:0] e [4];
    e = '{e0, e1, e2, e3};
    @(posedge sys_clk_in);
    sense_rd_in <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      @(posedge sys_clk_in);
      if (j == 3) sense_rd_in <= 1'b0;
      #1;
      cmp({sense_valid_out, sense_byte_out}, {1'b1, e[j]});
    end
    cmp(busy_out, 0);
  endtask

  // A hang counts as a mismatch
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up;
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk_in);
    #1;
    cmp({block_ready_out, status_err_out, busy_out, sense_valid_out, step_pulse_out, reread_ok_out,
      retry_limit_out}, {5'h00, 1'b1, 3'h4});
    $display("Reset check done");
    repeat (8) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    // --------------------------------
    // Every failure cause, row by row
    // --------------------------------
    for (int i = 0; i < 19; i++) begin
      for (int k = 0; k < 6; k++) b[k] = 8'(i * 37 + k * 91 + 5);
      b[5] = b[5] & 8'hc7;
      m_cause <= dcs_pkg::dcs_cause_t'(rows[i][10:6]);
      m_addr <= i[0];
      send(b);
      cmp(block_ready_out, 1);
      cmp({cmd_class_out, cmd_opcode_out, drive_sel_out, head_out}, {b[0], b[1][5:0]});
      cmp({cylinder_out, sector_out, count_out}, {b[2][7:6], b[3], b[2][5:0], b[4]});
      cmp({retry_off_out, reread_ok_out}, {b[5][7], ~b[5][6]});
      wait_done;
      cmp(retry_limit_out, (b[5][7] || rows[i][10:6] == 5'h0d) ? 0 : 4);
      cmp(status_err_out, i != 0);
      if (i != 0) sense({i[0], 1'b0, rows[i][5:0]}, {2'b00, b[1][5:0]}, b[2], b[3]);
      else cmp(busy_out, 0);
      $display("Row %0d done", i);
    end
    // Every step select; bytes written while busy must be ignored
    m_wait <= 8'h64;
    m_step <= 1'b1;
    m_cause <= dcs_pkg::DCS_CAUSE_NONE;
    for (int s = 0; s < 8; s++) begin
      b = '{8'h01, 8'h21, 8'h5a, 8'hc3, 8'h10, 8'(s)};
      send(b);
      send('{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
      cmp({block_ready_out, cylinder_out}, 11'h1c3);
      n = 0;
      while (step_pulse_out !== 1'b1 && n < 60) begin tick; n++; end
      n = 0;
      do begin tick; n++; end while (step_pulse_out !== 1'b1 && n < 60);
      cmp(n, s == 4 ? 20 : s == 5 ? 10 : 30);
      wait_done;
      $display("Step select %0d done", s);
    end
    // A new block while sense is pending drops the error status
    m_wait <= 8'h08;
    m_cause <= dcs_pkg::DCS_CAUSE_BAD_CMD;
    send(b);
    wait_done;
    cmp({status_err_out, busy_out}, 2'h3);
    @(posedge sys_clk_in);
    cmd_wr_in <= 1'b1;
    cmd_byte_in <= 8'h00;
    tick;
    cmp(status_err_out, 0);
    $display("Sense override done");
    wrap_up;
  end
endmodule
